// *** core/lbcm_local_bus_config_mailbox.sv ***
// Local bus setup register, local-to-host mailbox and the local bus
// pin logic that the setup steers.
// Assumes APB on mclk; local bus pins are asynchronous to mclk and
// the local clock runs well below mclk/4 so its edges can be found.
//
// Notes on behaviour
// RULE1: Mailbox irq bit raises host irq, host clears
// RULE2: Mailbox irq bit is write only
// RULE3: Mailbox holds byte 0 low, byte 1 next
// RULE4: Bit 20 disables cache line wrapping; code ends only linear bursts at the line end
// RULE5: Bit 19 picks ready input sampling edge
// RULE6: Bit 18 sets chip select active level
// RULE7: Bit 17 picks chip select sampling edge
// RULE8: Bit 16 sets ready output tri-state mode
// RULE9: Bit 15 extends ready until strobe inactive
// RULE10: Software avoids extend with whole-burst last beat
// RULE11: Bit 14 selects linear or interleaved bursts
// RULE12: Bit 13 sets local irq output level
// RULE13: Bit 12 sets last beat input level
// RULE14: Bit 11 sets address latch input level
// RULE15: Bit 10 sets ready output active level
// RULE16: Bits 9:8 select local data bus width
// RULE17: Bit 6 selects byte enable encoding
// RULE18: Setup bits 31:21 reserved, read zero
`timescale 1ns/1ps
`default_nettype none
module lbcm_local_bus_config_mailbox
    import lbcm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host side of the mailbox
    input wire logic hostIrqClear,
    output logic [15:0] hostMailboxData,
    output logic hostMailboxIrq,
    // Local bus pins
    input wire logic localClockIn,
    input wire logic chipChoose,
    input wire logic addrLatch,
    input wire logic addrStrobeN,
    input wire logic lastBurstBeatIn,
    input wire logic readyIn,
    input wire logic [3:0] localAddr,
    input wire logic localIrqRequest,
    output logic ackOut,
    output logic ackOutOe,
    output logic localIrqOut,
    output logic readyInSampled,
    output logic [3:0] burstOffset,
    output logic [3:0] byteLanes,
    output logic cycleActive
);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Next beat offset within a 16-byte line
    function automatic logic [3:0] nextOffset(input logic [3:0] start, input logic [3:0] cur,
                                              input logic interleave);
        logic [3:0] step;
        step = 4'h0;
        if (interleave) begin
            step = (((cur ^ start) + LBCM_BEAT_STEP) ^ start);
        end else begin
            step = cur + LBCM_BEAT_STEP;
        end
        return step;
    endfunction

    // Active-level decode of a configurable-polarity input
    function automatic logic isActive(input logic pin, input logic activeHigh);
        return activeHigh ? pin : ~pin;
    endfunction

    // Byte lanes of one beat for the selected width and encoding
    function automatic logic [3:0] laneMask(input logic [1:0] width, input logic encoded,
                                            input logic [1:0] lowAddr);
        logic [3:0] mask;
        mask = 4'h0;
        unique case (width)
            LBCM_BW_8: mask = 4'h1 << lowAddr;
            LBCM_BW_16: mask = lowAddr[1] ? 4'hC : 4'h3;
            LBCM_BW_32: mask = 4'hF;
            LBCM_BW_32ENC: mask = 4'hF;
        endcase
        // Encoded lanes are mirrored for 16 and 32-bit widths, big-endian lane zero first
        if (encoded && width != LBCM_BW_8) begin
            mask = {mask[0], mask[1], mask[2], mask[3]};
        end
        return mask;
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    logic [31:0] setupReg;
    logic [15:0] mailboxData;
    logic accessWrite;
    logic addrHit;
    logic [31:0] next_prdata;

    assign addrHit = (paddr == LBCM_ADDR_MAILBOX) || (paddr == LBCM_ADDR_SETUP);
    assign accessWrite = psel && penable && pwrite && (paddr == LBCM_ADDR_SETUP || paddr == LBCM_ADDR_MAILBOX);
    // Read data is fetched in the setup cycle, so access never waits
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrHit;

    // Setup register write, reserved and out-of-scope bits held at zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            setupReg <= LBCM_CFG_RESET;
        end else if (clkEnable && accessWrite && paddr == LBCM_ADDR_SETUP) begin
            setupReg <= pwdata & LBCM_CFG_MASK; // RULE18
        end
    end

    // Mailbox data bytes
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mailboxData <= LBCM_MB_DATA_RESET;
        end else if (clkEnable && accessWrite && paddr == LBCM_ADDR_MAILBOX) begin
            mailboxData <= pwdata[15:0]; // RULE3
        end
    end

    // Host interrupt: set wins over a clear in the same cycle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hostMailboxIrq <= 1'b0;
        end else if (clkEnable) begin
            if (accessWrite && paddr == LBCM_ADDR_MAILBOX && pwdata[LBCM_MB_IRQ_BIT]) begin
                hostMailboxIrq <= 1'b1; // RULE1
            end else if (hostIrqClear) begin
                hostMailboxIrq <= 1'b0; // RULE1
            end
        end
    end

    assign hostMailboxData = mailboxData;

    // Read mux; the irq bit never reads back
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == LBCM_ADDR_MAILBOX) begin
            next_prdata = {16'h0000, mailboxData}; // RULE2
        end else if (paddr == LBCM_ADDR_SETUP) begin
            next_prdata = setupReg; // RULE18
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (clkEnable && psel && !penable) begin
            prdata <= next_prdata;
        end
    end

    // --------------------------------------------------------------
    // Local bus pin synchronisers
    // --------------------------------------------------------------
    // Two stages for every pin; only stage two is looked at
    logic [10:0] pinMeta;
    logic [10:0] pinSync;
    logic clkPrev;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pinMeta <= 11'h000;
            pinSync <= 11'h000;
            clkPrev <= 1'b0;
        end else if (clkEnable) begin
            pinMeta <= {localClockIn, chipChoose, addrLatch, addrStrobeN, lastBurstBeatIn, readyIn,
                        localAddr, localIrqRequest};
            pinSync <= pinMeta;
            clkPrev <= pinSync[10];
        end
    end

    logic sClk, sCs, sAle, sStrobeN, sLast, sReady, sIrqReq;
    logic [3:0] sAddr;
    assign {sClk, sCs, sAle, sStrobeN, sLast, sReady, sAddr, sIrqReq} = pinSync;

    logic localRise, localFall, csEdge, readyEdge;
    assign localRise = sClk && !clkPrev;
    assign localFall = !sClk && clkPrev;
    assign csEdge = setupReg[LBCM_CFG_CS_FALL] ? localFall : localRise; // RULE7
    assign readyEdge = setupReg[LBCM_CFG_RDYIN_FALL] ? localFall : localRise; // RULE5

    // --------------------------------------------------------------
    // Sampled local inputs
    // --------------------------------------------------------------
    logic csActive;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            csActive <= 1'b0;
        end else if (clkEnable && csEdge) begin
            csActive <= isActive(sCs, setupReg[LBCM_CFG_CS_POL]); // RULE6
        end
    end

    // Rising-edge select must see the pin level of this very edge,
    // not the level held over from the previous burst
    logic csNow;
    assign csNow = setupReg[LBCM_CFG_CS_FALL] ? csActive : isActive(sCs, setupReg[LBCM_CFG_CS_POL]); // RULE7

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            readyInSampled <= 1'b0;
        end else if (clkEnable && readyEdge) begin
            readyInSampled <= sReady; // RULE5
        end
    end

    logic aleOn, lastOn, strobeOn;
    assign aleOn = isActive(sAle, setupReg[LBCM_CFG_ADDR_LATCH_POLARITY]); // RULE14
    assign lastOn = isActive(sLast, setupReg[LBCM_CFG_LAST_POL]); // RULE13
    assign strobeOn = !sStrobeN;

    // --------------------------------------------------------------
    // Local bus cycle sequencer
    // --------------------------------------------------------------
    lbcm_state_e state;
    logic [3:0] startOffset;
    logic ackActive;
    logic [3:0] afterBeat;
    logic wrapped;

    assign afterBeat = nextOffset(startOffset, burstOffset, setupReg[LBCM_CFG_BURST_IL]); // RULE11
    // Linear step that leaves the line ends the burst when wrap is off
    assign wrapped = !setupReg[LBCM_CFG_BURST_IL] && (afterBeat < burstOffset);

    // One beat per local rising edge; last beat input closes the burst
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= LBCM_IDLE;
            startOffset <= 4'h0;
            burstOffset <= 4'h0;
            ackActive <= 1'b0;
        end else if (clkEnable && localRise) begin
            unique case (state)
                LBCM_IDLE: begin
                    if (aleOn && csNow) begin
                        state <= LBCM_DATA;
                        startOffset <= sAddr;
                        burstOffset <= sAddr;
                        ackActive <= 1'b1;
                    end
                end
                LBCM_DATA: begin
                    if (lastOn || (setupReg[LBCM_CFG_WRAP_DIS] && wrapped)) begin
                        // RULE9
                        if (setupReg[LBCM_CFG_RDYOUT_EXT] && strobeOn) begin
                            state <= LBCM_HOLD;
                        end else begin
                            state <= LBCM_IDLE;
                            ackActive <= 1'b0;
                        end
                    end else begin
                        burstOffset <= afterBeat; // RULE4
                    end
                end
                LBCM_HOLD: begin
                    if (!strobeOn) begin
                        state <= LBCM_IDLE; // RULE9
                        ackActive <= 1'b0;
                    end
                end
                // Unused code: fall back to idle
                default: begin
                    state <= LBCM_IDLE;
                    ackActive <= 1'b0;
                end
            endcase
        end
    end

    assign cycleActive = (state != LBCM_IDLE);

    // --------------------------------------------------------------
    // Local bus outputs
    // --------------------------------------------------------------
    // Lanes follow width and encoding of the current beat
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            byteLanes <= 4'h0;
        end else if (clkEnable) begin
            byteLanes <= laneMask(setupReg[LBCM_CFG_BW_MSB:LBCM_CFG_BW_LSB], // RULE16
                                  setupReg[LBCM_CFG_BE_ENC], burstOffset[1:0]); // RULE17
        end
    end

    // Ready level and enable; open mode releases the pin when idle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ackOut <= 1'b1;
            ackOutOe <= 1'b0;
        end else if (clkEnable) begin
            ackOut <= ackActive ~^ setupReg[LBCM_CFG_ACK_POL]; // RULE15
            ackOutOe <= !setupReg[LBCM_CFG_RDYOUT_OE] || ackActive; // RULE8
        end
    end

    // Local irq pin, idle level follows polarity
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            localIrqOut <= 1'b1;
        end else if (clkEnable) begin
            localIrqOut <= sIrqReq ~^ setupReg[LBCM_CFG_IRQ_POL]; // RULE12
        end
    end
endmodule
`default_nettype wire

// *** core/lbcm_pkg.sv ***
// Constants for the local bus setup and local-to-host mailbox block.
// Assumes a 32-bit APB register port and a 100 MHz system clock.
package lbcm_pkg;
    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [15:0] LBCM_ADDR_MAILBOX = 16'h04F8;
    localparam logic [15:0] LBCM_ADDR_SETUP = 16'h04FC;

    // --------------------------------------------------------------
    // Mailbox fields
    // --------------------------------------------------------------
    localparam int LBCM_MB_BYTE0_LSB = 0;
    localparam int LBCM_MB_BYTE1_LSB = 8;
    localparam int LBCM_MB_IRQ_BIT = 16;
    localparam logic [15:0] LBCM_MB_DATA_RESET = 16'h0000;

    // --------------------------------------------------------------
    // Setup register fields
    // --------------------------------------------------------------
    localparam int LBCM_CFG_WRAP_DIS = 20;
    localparam int LBCM_CFG_RDYIN_FALL = 19;
    localparam int LBCM_CFG_CS_POL = 18;
    localparam int LBCM_CFG_CS_FALL = 17;
    localparam int LBCM_CFG_RDYOUT_OE = 16;
    localparam int LBCM_CFG_RDYOUT_EXT = 15;
    localparam int LBCM_CFG_BURST_IL = 14;
    localparam int LBCM_CFG_IRQ_POL = 13;
    localparam int LBCM_CFG_LAST_POL = 12;
    localparam int LBCM_CFG_ADDR_LATCH_POLARITY = 11;
    localparam int LBCM_CFG_ACK_POL = 10;
    localparam int LBCM_CFG_BW_MSB = 9;
    localparam int LBCM_CFG_BW_LSB = 8;
    localparam int LBCM_CFG_BE_ENC = 6;
    localparam logic [31:0] LBCM_CFG_RESET = 32'h0001_0B40;
    localparam logic [31:0] LBCM_CFG_MASK = 32'h001F_FF40;

    // --------------------------------------------------------------
    // Bus width codes
    // --------------------------------------------------------------
    localparam logic [1:0] LBCM_BW_8 = 2'h0;
    localparam logic [1:0] LBCM_BW_16 = 2'h1;
    localparam logic [1:0] LBCM_BW_32 = 2'h2;
    localparam logic [1:0] LBCM_BW_32ENC = 2'h3;

    // Burst beat step in bytes
    localparam logic [3:0] LBCM_BEAT_STEP = 4'h4;

    // Local bus cycle state, Gray coded along idle-data-hold
    typedef enum logic [1:0] {
        LBCM_IDLE = 2'b00,
        LBCM_DATA = 2'b01,
        LBCM_HOLD = 2'b11
    } lbcm_state_e;
endpackage

// *** testbench/lbcm_sva.sv ***
// Checker for the mailbox and setup register port of the block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lbcm_sva
    import lbcm_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic hostIrqClear,
    input wire logic [15:0] hostMailboxData,
    input wire logic hostMailboxIrq
);
    // ----------------------------------------
    // Decoded accesses
    // ----------------------------------------
    logic acc;
    logic mbWr;
    logic irqSet;
    // Only taken when the clock enable lets state advance
    assign acc = psel && penable && clkEnable;
    assign mbWr = acc && pwrite && paddr == LBCM_ADDR_MAILBOX;
    assign irqSet = mbWr && pwdata[LBCM_MB_IRQ_BIT];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_irq_set: assert property (irqSet |=> hostMailboxIrq)
        else $error("host irq not raised by mailbox write");
    chk_irq_holds: assert property (hostMailboxIrq && !hostIrqClear |=> hostMailboxIrq)
        else $error("host irq dropped without clear");
    chk_irq_clears: assert property (hostMailboxIrq && hostIrqClear && clkEnable && !irqSet |=> !hostMailboxIrq)
        else $error("host irq not cleared");
    chk_irq_cause: assert property ($rose(hostMailboxIrq) |-> $past(irqSet))
        else $error("host irq rose without request");
    chk_mb_wonly: assert property (acc && !pwrite && paddr == LBCM_ADDR_MAILBOX |-> prdata[31:16] == 16'h0000)
        else $error("mailbox upper bits read nonzero");
    chk_mb_bytes: assert property (mbWr |=> hostMailboxData == $past(pwdata[15:0]))
        else $error("mailbox bytes not taken");
    chk_mb_keep: assert property (!mbWr |=> $stable(hostMailboxData))
        else $error("mailbox bytes changed without write");
    chk_cfg_resv: assert property (acc && !pwrite && paddr == LBCM_ADDR_SETUP |-> prdata[31:21] == 11'h000)
        else $error("setup reserved bits read nonzero");
    cov_irq_set: cover property (irqSet ##1 hostMailboxIrq);
    cov_irq_clr: cover property (hostMailboxIrq && hostIrqClear);
    cov_cfg_rd: cover property (acc && !pwrite && paddr == LBCM_ADDR_SETUP);
endmodule
bind lbcm_local_bus_config_mailbox lbcm_sva chk (.mclk, .reset, .clkEnable, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .hostIrqClear, .hostMailboxData, .hostMailboxIrq);
`default_nettype wire

// *** testbench/lbcm_local_master.sv ***
// Local processor bus model: runs bursts of one address edge and three beats at 125 ns.
// Assumes the bench sets the pin polarities to match the setup.
`timescale 1ns/1ps
`default_nettype none
module lbcm_local_master (
    input wire logic csPol,
    input wire logic alePol,
    input wire logic lastPol,
    input wire logic [3:0] burstOffset,
    input wire logic ackOut,
    input wire logic ackOutOe,
    output logic localClockIn,
    output logic chipChoose,
    output logic addrLatch,
    output logic addrStrobeN,
    output logic lastBurstBeatIn,
    output logic readyIn,
    output logic [3:0] localAddr
);
    // Idle pins; clock stands low between frames
    initial begin
        localClockIn = 1'b0;
        chipChoose = 1'b1;
        addrLatch = 1'b0;
        addrStrobeN = 1'b1;
        lastBurstBeatIn = 1'b1;
        readyIn = 1'b0;
        localAddr = 4'h0;
    end
    // One burst; offsets caught just before each next rising edge
    task automatic burst(input logic [3:0] start, output logic [3:0] seen [3], output logic [1:0] ack [3]);
        localAddr = start;
        chipChoose = csPol;
        addrLatch = alePol;
        for (int k = 0; k < 4; k++) begin
            #31.25;
            if (k > 0) begin
                seen[k-1] = burstOffset;
                ack[k-1] = {ackOutOe, ackOut};
                addrLatch = !alePol;
            end
            lastBurstBeatIn = (k == 3) ? lastPol : !lastPol;
            readyIn = 1'b1;
            #31.25 localClockIn = 1'b1;
            // Ready high at each rise, low at each fall: the chosen edge shows
            #31.25 readyIn = 1'b0;
            #31.25 localClockIn = 1'b0;
        end
        // Released pins show the inverse, never the last value
        chipChoose = !csPol;
        lastBurstBeatIn = !lastPol;
        localAddr = ~start;
    endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench: APB register port, mailbox and local bursts.
// Assumes the design package and the local bus model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lbcm_pkg::*;
    logic mclk = 1'b0, reset = 1'b1, clkEnable = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hostIrqClear = 1'b0, localIrqRequest = 1'b0, csPol = 1'b0, alePol = 1'b1, lastPol = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, r, d, cfg, rnd;
    logic pready, pslverr, slv, hostMailboxIrq, localClockIn, chipChoose, addrLatch, addrStrobeN;
    logic lastBurstBeatIn, readyIn, ackOut, ackOutOe, localIrqOut, cycleActive, expIrq, il, oe, ap, ip;
    logic readyInSampled, rf, enc;
    logic [1:0] bw;
    logic [15:0] hostMailboxData;
    logic [3:0] localAddr, burstOffset, byteLanes, seen [3];
    logic [1:0] ack [3];
    int err_total = 0, check_count = 0, cycles = 0;
    lbcm_local_bus_config_mailbox uut (.mclk, .reset, .clkEnable, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hostIrqClear, .hostMailboxData, .hostMailboxIrq, .localClockIn, .chipChoose,
        .addrLatch, .addrStrobeN, .lastBurstBeatIn, .readyIn, .localAddr, .localIrqRequest, .ackOut, .ackOutOe,
        .localIrqOut, .readyInSampled, .burstOffset, .byteLanes, .cycleActive);
    lbcm_local_master lm (.csPol, .alePol, .lastPol, .burstOffset, .ackOut, .ackOutOe, .localClockIn, .chipChoose,
        .addrLatch, .addrStrobeN, .lastBurstBeatIn, .readyIn, .localAddr);
    // ----------------------------------------
    // Clock, timeout, helpers
    // ----------------------------------------
    initial forever #5 mclk = ~mclk;
    // Whole run needs about 600 cycles; a hang is cut at 6000
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Expected beat offset: XOR for interleaved, add for linear
    function automatic logic [3:0] beatOff(input logic [3:0] s, input int k, input logic i);
        return i ? s ^ 4'(k * 4) : s + 4'(k * 4);
    endfunction
    // Expected lanes of a line-aligned beat; encoded mode mirrors them above 8-bit width
    function automatic logic [3:0] lanesExp(input logic [1:0] w, input logic e);
        if (w == LBCM_BW_8) return 4'h1;
        if (w == LBCM_BW_16) return e ? 4'hC : 4'h3;
        return 4'hF;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("counts: checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rnd = 32'h0000_1376;
        expIrq = 1'b0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, LBCM_ADDR_SETUP, 32'h0, r);
        chk("setup reset", 32'h0001_0B40, r);
        apb(1'b0, 16'h0500, 32'h0, r);
        chk("unmapped read", 32'h0, r);
        chk("unmapped slverr", 32'h1, slv);
        // Mailbox: random bytes, irq set, read back, host clear
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            d = rnd;
            d[16] = (i == 0) ? 1'b1 : d[16];
            apb(1'b1, LBCM_ADDR_MAILBOX, d, r);
            expIrq = expIrq | d[16];
            @(posedge mclk);
            #1 chk("mailbox data", d[15:0], hostMailboxData);
            chk("host irq", expIrq, hostMailboxIrq);
            apb(1'b0, LBCM_ADDR_MAILBOX, 32'h0, r);
            chk("mailbox read", {16'h0000, d[15:0]}, r);
            if (expIrq && i[0]) begin
                @(posedge mclk) hostIrqClear <= 1'b1;
                @(posedge mclk) hostIrqClear <= 1'b0;
                #1 chk("irq cleared", 32'h0, hostMailboxIrq);
                expIrq = 1'b0;
            end
        end
        // Setup: random writes, reserved bits dropped
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            d = rnd;
            d[15] = 1'b0;
            apb(1'b1, LBCM_ADDR_SETUP, d, r);
            apb(1'b0, LBCM_ADDR_SETUP, 32'h0, r);
            chk("setup read", d & 32'h001F_FF40, r);
        end
        // Local bursts over the four word start offsets 0, 4, 8 and 12, both orders, random levels
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            il = i[2];
            {csPol, lastPol, alePol, ap, oe, ip} = rnd[5:0];
            {enc, bw, rf} = rnd[10:7];
            localIrqRequest <= rnd[6];
            cfg = {12'h0, rf, csPol, 1'b0, oe, 1'b0, il, ip, lastPol, alePol, ap, bw, 1'b0, enc, 6'h00};
            apb(1'b1, LBCM_ADDR_SETUP, cfg, r);
            lm.burst({i[1:0], 2'b00}, seen, ack);
            for (int k = 0; k < 3; k++) begin
                chk("beat offset", beatOff({i[1:0], 2'b00}, k, il), seen[k]);
                if (k > 0) chk("beat ack", {1'b1, ap}, ack[k]);
            end
            repeat (4) @(posedge mclk);
            #1 chk("idle cycle", 32'h0, cycleActive);
            chk("idle ack oe", !oe, ackOutOe);
            if (!oe) chk("idle ack", !ap, ackOut);
            chk("local irq", rnd[6] ? ip : !ip, localIrqOut);
            chk("byte lanes", lanesExp(bw, enc), byteLanes);
            chk("ready sample", !rf, readyInSampled);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
